// ==== verilog/pds_ea_unit.sv ====
// What this block does
// [RULE1] separate page registers for data reads and data writes
// [RULE2] one move reads via read page and writes via write page
// [RULE3] read page may sit in program window while write page is extended
// [RULE4] a crossing clears address bit 15 before any page correction
// [RULE5] crossings count only when the start address is in a paged window
// [RULE6] only pre or post modified indirect steps pages; register offset never
// [RULE7] overflow increments the active page and sets address bit 15
// [RULE8] underflow decrements the active page and sets address bit 15
// [RULE9] multi-page linear space only through register indirect modes
// [RULE10] offset, modulo, bit-reversed crossings set bit 15, page unchanged
// [RULE11] page zero, extended and window edges override the normal step
// [RULE12] overflow on last extended page keeps page, clears bit 15
// [RULE13] extended access with page zero raises an address error
// [RULE14] program space writes through the write page raise an address error
// [RULE15] addresses with bit 15 clear go to base space, pages ignored
`timescale 1ns/1ps
`include "pds_cfg.svh"

module pds_ea_unit
    import pds_pkg::*;
#(
    parameter int ADDR_W = `PDS_ADDR_W,
    parameter int PAGE_W = `PDS_PAGE_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // page register load from the core
    input  wire logic              pageLoadEn,
    input  wire logic              pageLoadWrite,
    input  wire logic [PAGE_W-1:0] pageLoadData,
    // address request
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire pds_mode_type      reqMode,
    input  wire logic [ADDR_W-1:0] reqBase,
    input  wire logic [ADDR_W-1:0] reqModifier,
    // address answer
    output logic                   ackValid_q,
    output logic [ADDR_W-1:0]      accessAddr_q,
    output logic [PAGE_W-1:0]      accessPage_q,
    output pds_space_type          accessSpace_q,
    output logic [ADDR_W-1:0]      pointer_q,
    output logic                   pageStepped_q,
    output logic                   wrapped_q,
    output logic                   addrErr_q,
    output pds_err_type            errCause_q,
    // page register view
    output logic [PAGE_W-1:0]      readPage,
    output logic [PAGE_W-1:0]      writePage
);
    // ****************************************************
    // page registers and adder
    // ****************************************************
    pds_step_if #(.PAGE_W(PAGE_W)) stepBus ();

    pds_page_regs #(.PAGE_W(PAGE_W)) pageRegs (
        .clk       (clk),
        .rst       (rst),
        .loadEn    (pageLoadEn),
        .loadWrite (pageLoadWrite),
        .loadData  (pageLoadData),
        .step      (stepBus.regs)
    );

    logic [ADDR_W-1:0] rawAddr;
    logic              overflow;
    logic              underflow;

    pds_ea_calc #(.ADDR_W(ADDR_W)) eaCalc (
        .base      (reqBase),
        .modifier  (reqModifier),
        .rawAddr   (rawAddr),
        .overflow  (overflow),
        .underflow (underflow)
    );

    assign readPage  = stepBus.readPage;
    assign writePage = stepBus.writePage;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic pds_space_type spaceOf(input logic win,
                                              input logic [PAGE_W-1:0] p);
        if (!win) begin
            spaceOf = PDS_SPACE_BASE; // [RULE15]
        end else if (p == `PDS_PAGE_ZERO) begin
            spaceOf = PDS_SPACE_ZERO;
        end else if (p <= `PDS_EDS_LAST) begin
            spaceOf = PDS_SPACE_EDS;
        end else if (p <= `PDS_LSW_LAST) begin
            spaceOf = PDS_SPACE_LSW;
        end else begin
            spaceOf = PDS_SPACE_MSB;
        end
    endfunction

    function automatic logic isPaged(input pds_space_type s);
        isPaged = (s != PDS_SPACE_BASE) && (s != PDS_SPACE_ZERO);
    endfunction

    // overflow off the last extended or last window page cannot step up
    function automatic logic atTopEdge(input logic [PAGE_W-1:0] p);
        atTopEdge = (p == `PDS_EDS_LAST) || (p == `PDS_MSB_LAST);
    endfunction

    // underflow below the first extended or first low-word page cannot step down
    function automatic logic atBottomEdge(input logic [PAGE_W-1:0] p);
        atBottomEdge = (p == `PDS_EDS_FIRST) || (p == `PDS_LSW_FIRST);
    endfunction

    // program space is read-only through the window
    function automatic logic isProgram(input pds_space_type s);
        isProgram = (s == PDS_SPACE_LSW) || (s == PDS_SPACE_MSB);
    endfunction

    // ****************************************************
    // mode decode
    // ****************************************************
    logic              modified;
    logic              stepMode;
    logic              preAccess;
    logic              movesPointer;
    logic [PAGE_W-1:0] activePage;
    pds_space_type     startSpace;
    logic              startPaged;

    always_comb begin
        modified     = 1'b0;
        stepMode     = 1'b0;
        preAccess    = 1'b0;
        movesPointer = 1'b0;
        case (reqMode)
            PDS_MODE_PRE_MOD: begin
                modified     = 1'b1;
                stepMode     = 1'b1; // [RULE6]
                preAccess    = 1'b1;
                movesPointer = 1'b1;
            end
            PDS_MODE_POST_MOD: begin
                modified     = 1'b1;
                stepMode     = 1'b1; // [RULE6]
                movesPointer = 1'b1;
            end
            PDS_MODE_REG_OFFSET: begin
                modified  = 1'b1;
                preAccess = 1'b1;
            end
            PDS_MODE_MODULO,
            PDS_MODE_BIT_REV: begin
                modified     = 1'b1;
                movesPointer = 1'b1;
            end
            PDS_MODE_DIRECT,
            PDS_MODE_IND_PLAIN: begin
                // pointer used as it stands, no page effect
                modified = 1'b0;
            end
            default: begin
                modified = 1'b0;
            end
        endcase
    end

    // reads follow the read page, writes the write page, so one move spans both
    assign activePage = reqWrite ? stepBus.writePage : stepBus.readPage; // [RULE2] [RULE3]
    assign startSpace = spaceOf(reqBase[`PDS_WIN_BIT], activePage);
    assign startPaged = isPaged(startSpace); // [RULE5]

    // ****************************************************
    // crossing and boundary handling
    // ****************************************************
    logic              crossing;
    logic [ADDR_W-1:0] newAddr;
    logic [PAGE_W-1:0] newPage;
    logic              doStep;
    logic              stepUp;
    logic              wrapped;

    assign crossing = modified && (overflow || underflow);

    always_comb begin
        newAddr = modified ? rawAddr : reqBase; // [RULE9]
        newPage = activePage;
        doStep  = 1'b0;
        stepUp  = overflow;
        wrapped = 1'b0;
        if (crossing && stepMode && startPaged) begin
            // raw sum already has bit 15 clear here
            newAddr = rawAddr; // [RULE4]
            if (overflow) begin
                if (atTopEdge(activePage)) begin
                    newAddr[`PDS_WIN_BIT] = 1'b0; // [RULE11] [RULE12]
                end else begin
                    newPage               = PAGE_W'(activePage + 1'b1); // [RULE7]
                    doStep                = 1'b1;
                    newAddr[`PDS_WIN_BIT] = 1'b1; // [RULE7]
                end
            end else begin
                if (atBottomEdge(activePage)) begin
                    newAddr[`PDS_WIN_BIT] = 1'b0; // [RULE11]
                end else begin
                    newPage               = PAGE_W'(activePage - 1'b1); // [RULE8]
                    doStep                = 1'b1;
                    newAddr[`PDS_WIN_BIT] = 1'b1; // [RULE8]
                end
            end
        end else if (crossing) begin
            // wrap inside the current page
            newAddr[`PDS_WIN_BIT] = 1'b1; // [RULE10]
            wrapped               = 1'b1;
        end
    end

    // ****************************************************
    // access target and address error
    // ****************************************************
    logic [ADDR_W-1:0] accessAddr;
    logic [PAGE_W-1:0] accessPage;
    pds_space_type     accessSpace;
    pds_err_type       errCause;

    assign accessAddr  = preAccess ? newAddr : reqBase;
    assign accessPage  = (reqMode == PDS_MODE_PRE_MOD) ? newPage : activePage;
    assign accessSpace = spaceOf(accessAddr[`PDS_WIN_BIT], accessPage);

    always_comb begin
        errCause = PDS_ERR_NONE;
        if (accessSpace == PDS_SPACE_ZERO) begin
            errCause = PDS_ERR_PAGE_ZERO; // [RULE13]
        end else if (reqWrite && isProgram(accessSpace)) begin
            errCause = PDS_ERR_PS_WRITE; // [RULE14]
        end
    end

    // ****************************************************
    // page step request
    // ****************************************************
    logic stepAllowed;

    // a trapped access leaves the page registers alone so software can retry
    assign stepAllowed       = doStep && (errCause == PDS_ERR_NONE);
    assign stepBus.stepEn    = reqValid && stepAllowed;
    assign stepBus.stepUp    = stepUp;
    // only the register that serves this access moves
    assign stepBus.stepWrite = reqWrite; // [RULE1]

    // ****************************************************
    // answer registers
    // ****************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackValid_q <= 1'b0;
        end else begin
            ackValid_q <= reqValid;
        end
    end

    // one-cycle trap pulse; the cause stays with the data outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrErr_q <= 1'b0;
        end else begin
            addrErr_q <= reqValid && (errCause != PDS_ERR_NONE);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accessAddr_q <= '0;
            accessPage_q <= '0;
        end else if (reqValid) begin
            accessAddr_q <= accessAddr;
            accessPage_q <= accessPage;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accessSpace_q <= PDS_SPACE_BASE;
            errCause_q    <= PDS_ERR_NONE;
        end else if (reqValid) begin
            accessSpace_q <= accessSpace;
            errCause_q    <= errCause;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pointer_q <= '0;
        end else if (reqValid) begin
            // register offset never writes the pointer back
            pointer_q <= movesPointer ? newAddr : reqBase; // [RULE6]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pageStepped_q <= 1'b0;
            wrapped_q     <= 1'b0;
        end else if (reqValid) begin
            pageStepped_q <= stepAllowed;
            wrapped_q     <= wrapped;
        end
    end
endmodule

// ==== verilog/pds_cfg.svh ====
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH

// widths
`define PDS_ADDR_W        16
`define PDS_PAGE_W        10
`define PDS_WIN_BIT       15

// page map boundaries
`define PDS_PAGE_ZERO     10'h000
`define PDS_EDS_FIRST     10'h001
`define PDS_EDS_LAST      10'h1FF
`define PDS_LSW_FIRST     10'h200
`define PDS_LSW_LAST      10'h2FF
`define PDS_MSB_FIRST     10'h300
`define PDS_MSB_LAST      10'h3FF

// reset values of the page registers
`define PDS_RD_PAGE_RST   10'h001
`define PDS_WR_PAGE_RST   10'h001

`endif

// ==== verilog/pds_pkg.sv ====
package pds_pkg;

    typedef enum logic [2:0] {
        PDS_MODE_DIRECT,
        PDS_MODE_IND_PLAIN,
        PDS_MODE_PRE_MOD,
        PDS_MODE_POST_MOD,
        PDS_MODE_REG_OFFSET,
        PDS_MODE_MODULO,
        PDS_MODE_BIT_REV
    } pds_mode_type;

    typedef enum logic [2:0] {
        PDS_SPACE_BASE,
        PDS_SPACE_ZERO,
        PDS_SPACE_EDS,
        PDS_SPACE_LSW,
        PDS_SPACE_MSB
    } pds_space_type;

    typedef enum logic [1:0] {
        PDS_ERR_NONE,
        PDS_ERR_PAGE_ZERO,
        PDS_ERR_PS_WRITE
    } pds_err_type;

endpackage

// ==== verilog/pds_step_if.sv ====
`timescale 1ns/1ps
`include "pds_cfg.svh"

interface pds_step_if #(parameter int PAGE_W = `PDS_PAGE_W);
    logic              stepEn;
    logic              stepUp;
    logic              stepWrite;
    logic [PAGE_W-1:0] readPage;
    logic [PAGE_W-1:0] writePage;

    modport regs (input stepEn, stepUp, stepWrite, output readPage, writePage);
    modport user (output stepEn, stepUp, stepWrite, input readPage, writePage);
endinterface

// ==== verilog/pds_page_regs.sv ====
`timescale 1ns/1ps
`include "pds_cfg.svh"

module pds_page_regs #(
    parameter int PAGE_W = `PDS_PAGE_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // software load
    input  wire logic              loadEn,
    input  wire logic              loadWrite,
    input  wire logic [PAGE_W-1:0] loadData,
    // step port
    pds_step_if.regs               step
);
    logic [PAGE_W-1:0] readPage_q;
    logic [PAGE_W-1:0] writePage_q;

    function automatic logic [PAGE_W-1:0] stepPage(input logic [PAGE_W-1:0] p,
                                                   input logic up);
        stepPage = up ? PAGE_W'(p + 1'b1) : PAGE_W'(p - 1'b1);
    endfunction

    // a software load in the same cycle as a step wins: the program owns the page
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readPage_q <= `PDS_RD_PAGE_RST;
        end else if (loadEn && !loadWrite) begin
            readPage_q <= loadData;
        end else if (step.stepEn && !step.stepWrite) begin
            readPage_q <= stepPage(readPage_q, step.stepUp); // [RULE1]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            writePage_q <= `PDS_WR_PAGE_RST;
        end else if (loadEn && loadWrite) begin
            writePage_q <= loadData;
        end else if (step.stepEn && step.stepWrite) begin
            writePage_q <= stepPage(writePage_q, step.stepUp); // [RULE1]
        end
    end

    assign step.readPage  = readPage_q;
    assign step.writePage = writePage_q;
endmodule

// ==== verilog/pds_ea_calc.sv ====
`timescale 1ns/1ps
`include "pds_cfg.svh"

module pds_ea_calc #(
    parameter int ADDR_W = `PDS_ADDR_W
) (
    // operands
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic [ADDR_W-1:0] modifier,
    // result
    output logic      [ADDR_W-1:0] rawAddr,
    output logic                   overflow,
    output logic                   underflow
);
    logic [ADDR_W:0] sum;

    // the modifier is two's complement; only a window address can cross
    assign sum       = {1'b0, base} + {1'b0, modifier};
    assign rawAddr   = sum[ADDR_W-1:0];
    assign overflow  = base[ADDR_W-1] && !modifier[ADDR_W-1] && sum[ADDR_W];
    assign underflow = base[ADDR_W-1] && modifier[ADDR_W-1] && !rawAddr[ADDR_W-1];
endmodule

// ==== dv/pds_ea_unit_properties.sv ====
`timescale 1ns/1ps
module pds_ea_unit_properties
    import pds_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int PAGE_W = 10
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // page load
    input wire logic              pageLoadEn,
    input wire logic              pageLoadWrite,
    input wire logic [PAGE_W-1:0] pageLoadData,
    // request
    input wire logic              reqValid,
    input wire logic              reqWrite,
    input wire pds_mode_type      reqMode,
    input wire logic [ADDR_W-1:0] reqBase,
    input wire logic [ADDR_W-1:0] reqModifier,
    // answer
    input wire logic              ackValid_q,
    input wire logic [ADDR_W-1:0] accessAddr_q,
    input wire logic [PAGE_W-1:0] accessPage_q,
    input wire pds_space_type     accessSpace_q,
    input wire logic [ADDR_W-1:0] pointer_q,
    input wire logic              pageStepped_q,
    input wire logic              wrapped_q,
    input wire logic              addrErr_q,
    input wire pds_err_type       errCause_q,
    input wire logic [PAGE_W-1:0] readPage,
    input wire logic [PAGE_W-1:0] writePage
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // carry out of the unsigned sum marks a crossing upward
    logic [ADDR_W:0] sumW;
    assign sumW = {1'b0, reqBase} + {1'b0, reqModifier};

    a_ack_follows: assert property (reqValid |=> ackValid_q)
        else $error("no answer after request");
    a_ack_quiet: assert property (!reqValid |=> !ackValid_q && !addrErr_q)
        else $error("answer without request");
    a_load_split: assert property (pageLoadEn && !pageLoadWrite && !reqValid |=>
        readPage == $past(pageLoadData) && $stable(writePage))
        else $error("read page load leaked");
    a_offset_nostep: assert property (reqValid && reqMode == PDS_MODE_REG_OFFSET
        |=> !pageStepped_q) else $error("offset mode stepped page");
    a_wrap_page_kept: assert property (reqValid && !pageLoadEn &&
        (reqMode == PDS_MODE_MODULO || reqMode == PDS_MODE_BIT_REV)
        |=> $stable(readPage) && $stable(writePage)) else $error("wrap mode moved page");
    a_base_direct: assert property (reqValid && reqMode == PDS_MODE_DIRECT
        && !reqBase[ADDR_W-1] |=> !addrErr_q && accessSpace_q == PDS_SPACE_BASE)
        else $error("base access misrouted");
    a_ps_write: assert property (reqValid && reqWrite && reqMode == PDS_MODE_DIRECT
        && reqBase[ADDR_W-1] && writePage >= 10'h200
        |=> addrErr_q && errCause_q == PDS_ERR_PS_WRITE) else $error("no program write trap");
    a_zero_trap: assert property (reqValid && reqMode == PDS_MODE_DIRECT
        && reqBase[ADDR_W-1] && (reqWrite ? writePage : readPage) == 10'h000
        |=> addrErr_q && errCause_q == PDS_ERR_PAGE_ZERO) else $error("no page zero trap");
    a_step_up: assert property (reqValid && !reqWrite && reqMode == PDS_MODE_POST_MOD
        && reqBase[ADDR_W-1] && !reqModifier[ADDR_W-1] && sumW[ADDR_W] && !pageLoadEn
        && readPage > 10'h000 && readPage < 10'h1FF
        |=> readPage == $past(readPage) + 10'h001 && pageStepped_q && pointer_q[ADDR_W-1])
        else $error("overflow did not step up");
    a_step_down: assert property (reqValid && reqWrite && reqMode == PDS_MODE_PRE_MOD
        && reqBase[ADDR_W-1] && reqModifier[ADDR_W-1] && !sumW[ADDR_W-1] && !pageLoadEn
        && writePage > 10'h001 && writePage < 10'h200
        |=> writePage == $past(writePage) - 10'h001 && accessAddr_q[ADDR_W-1])
        else $error("underflow did not step down");
endmodule

bind pds_ea_unit pds_ea_unit_properties #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) u_props (
    .clk(clk), .rst(rst), .pageLoadEn(pageLoadEn), .pageLoadWrite(pageLoadWrite),
    .pageLoadData(pageLoadData), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqMode(reqMode), .reqBase(reqBase), .reqModifier(reqModifier),
    .ackValid_q(ackValid_q), .accessAddr_q(accessAddr_q), .accessPage_q(accessPage_q),
    .accessSpace_q(accessSpace_q), .pointer_q(pointer_q), .pageStepped_q(pageStepped_q),
    .wrapped_q(wrapped_q), .addrErr_q(addrErr_q), .errCause_q(errCause_q),
    .readPage(readPage), .writePage(writePage));

// ==== dv/pds_agu_model.sv ====
`timescale 1ns/1ps
module pds_agu_model
    import pds_pkg::*;
(
    // clock
    input  wire logic   clk,
    // page load
    output logic        pageLoadEn,
    output logic        pageLoadWrite,
    output logic [9:0]  pageLoadData,
    // request
    output logic        reqValid,
    output logic        reqWrite,
    output pds_mode_type reqMode,
    output logic [15:0] reqBase,
    output logic [15:0] reqModifier
);
    initial begin
        pageLoadEn = 1'b0;
        pageLoadWrite = 1'b0;
        pageLoadData = 10'h000;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqMode = PDS_MODE_DIRECT;
        reqBase = 16'h0000;
        reqModifier = 16'h0000;
    end

    // called at a falling edge; valid held so requests can run back to back
    task automatic req(input logic w, input pds_mode_type m, input logic [15:0] b, d);
        reqWrite = w;
        reqMode = m;
        reqBase = b;
        reqModifier = d;
        reqValid = 1'b1;
        @(negedge clk);
    endtask

    task automatic idle();
        reqValid = 1'b0;
        @(negedge clk);
    endtask

    // extra idle cycle so two loads never assign the strobe in one step
    task automatic load(input logic w, input logic [9:0] p);
        pageLoadWrite = w;
        pageLoadData = p;
        pageLoadEn = 1'b1;
        @(negedge clk);
        pageLoadEn = 1'b0;
        @(negedge clk);
    endtask
endmodule

// ==== dv/pds_ea_unit_tb_top.sv ====
`timescale 1ns/1ps
module pds_ea_unit_tb_top;
    import pds_pkg::*;
    logic clk, rst, pageLoadEn, pageLoadWrite, reqValid, reqWrite;
    logic ackValid_q, pageStepped_q, wrapped_q, addrErr_q;
    logic [9:0] pageLoadData, accessPage_q, readPage, writePage;
    logic [15:0] reqBase, reqModifier, accessAddr_q, pointer_q;
    pds_mode_type reqMode;
    pds_space_type accessSpace_q;
    pds_err_type errCause_q;
    int n_fail = 0;
    int num_checks = 0;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    pds_agu_model agu (.clk(clk), .pageLoadEn(pageLoadEn), .pageLoadWrite(pageLoadWrite),
        .pageLoadData(pageLoadData), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqMode(reqMode), .reqBase(reqBase), .reqModifier(reqModifier));
    pds_ea_unit dut (.clk(clk), .rst(rst), .pageLoadEn(pageLoadEn),
        .pageLoadWrite(pageLoadWrite), .pageLoadData(pageLoadData), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqMode(reqMode), .reqBase(reqBase), .reqModifier(reqModifier),
        .ackValid_q(ackValid_q), .accessAddr_q(accessAddr_q), .accessPage_q(accessPage_q),
        .accessSpace_q(accessSpace_q), .pointer_q(pointer_q), .pageStepped_q(pageStepped_q),
        .wrapped_q(wrapped_q), .addrErr_q(addrErr_q), .errCause_q(errCause_q),
        .readPage(readPage), .writePage(writePage));

    task automatic chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_reset();
        chk(readPage, 16'h0001);
        chk(writePage, 16'h0001);
    endtask

    // one move: read from program window page, write to extended page
    task automatic t_move();
        agu.load(1'b0, 10'h250);
        agu.load(1'b1, 10'h020);
        agu.req(1'b0, PDS_MODE_DIRECT, 16'h9000, 16'h0000);
        chk(accessPage_q, 16'h0250);
        chk(accessSpace_q, PDS_SPACE_LSW);
        agu.req(1'b1, PDS_MODE_DIRECT, 16'h9000, 16'h0000);
        chk(accessPage_q, 16'h0020);
        chk({addrErr_q, accessSpace_q}, PDS_SPACE_EDS);
        chk(readPage, 16'h0250);
        agu.idle();
    endtask

    task automatic t_steps();
        agu.load(1'b0, 10'h005);
        agu.req(1'b0, PDS_MODE_POST_MOD, 16'hFFFE, 16'h0002);
        chk({ackValid_q, pageStepped_q}, 16'h0003);
        chk(accessAddr_q, 16'hFFFE);
        chk(pointer_q, 16'h8000);
        chk(readPage, 16'h0006);
        agu.idle();
        agu.load(1'b1, 10'h010);
        agu.req(1'b1, PDS_MODE_PRE_MOD, 16'h8000, 16'hFFFE);
        agu.idle();
        chk(accessAddr_q, 16'hFFFE);
        chk(accessPage_q, 16'h000F);
        chk(writePage, 16'h000F);
        agu.req(1'b0, PDS_MODE_POST_MOD, 16'h7FFE, 16'h0002);
        agu.idle();
        chk({pageStepped_q, readPage}, 16'h0006);
    endtask

    task automatic t_edges();
        logic [9:0] pb[6] = '{10'h1FF, 10'h2FF, 10'h3FF, 10'h001, 10'h200, 10'h300};
        logic [9:0] pa[6] = '{10'h1FF, 10'h300, 10'h3FF, 10'h001, 10'h200, 10'h2FF};
        logic [15:0] pt[6] = '{16'h0000, 16'h8000, 16'h0000, 16'h7FFE, 16'h7FFE, 16'hFFFE};
        for (int i = 0; i < 6; i++) begin
            agu.load(1'b0, pb[i]);
            if (i < 3) begin
                agu.req(1'b0, PDS_MODE_POST_MOD, 16'hFFFE, 16'h0002);
            end else begin
                agu.req(1'b0, PDS_MODE_POST_MOD, 16'h8000, 16'hFFFE);
            end
            agu.idle();
            chk(readPage, pa[i]);
            chk(pointer_q, pt[i]);
        end
    endtask

    task automatic t_wrap();
        pds_mode_type md[5] = '{PDS_MODE_REG_OFFSET, PDS_MODE_MODULO, PDS_MODE_BIT_REV,
                                PDS_MODE_DIRECT, PDS_MODE_IND_PLAIN};
        agu.load(1'b0, 10'h005);
        for (int i = 0; i < 5; i++) begin
            agu.req(1'b0, md[i], 16'hFFFE, 16'h0002);
            agu.idle();
            chk({pageStepped_q, readPage}, 16'h0005);
            chk(wrapped_q, i < 3);
            chk(accessAddr_q, (i == 0) ? 16'h8000 : 16'hFFFE);
            chk(pointer_q, (i == 1 || i == 2) ? 16'h8000 : 16'hFFFE);
        end
    endtask

    task automatic t_traps();
        agu.load(1'b1, 10'h300);
        agu.req(1'b1, PDS_MODE_DIRECT, 16'h8000, 16'h0000);
        chk({addrErr_q, errCause_q}, {1'b1, PDS_ERR_PS_WRITE});
        agu.idle();
        agu.load(1'b0, 10'h000);
        agu.req(1'b0, PDS_MODE_DIRECT, 16'h8000, 16'h0000);
        chk({addrErr_q, errCause_q}, {1'b1, PDS_ERR_PAGE_ZERO});
        agu.req(1'b0, PDS_MODE_DIRECT, 16'h1234, 16'h0000);
        chk({addrErr_q, accessSpace_q}, PDS_SPACE_BASE);
        chk(accessAddr_q, 16'h1234);
        agu.idle();
    endtask

    initial begin
        #400000;
        n_fail++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_move();
        t_steps();
        t_edges();
        t_wrap();
        t_traps();
        complete_run();
    end
endmodule
